/* verilog/olz_config_regs.sv */
// top: output loop zero configuration register bank on an Avalon-MM slave
//
// Functional notes
// R1 - the low seven bits of the pump register are a current code of n steps; bit 7 is reserved.
// R2 - after reset the pump current code is forty-six.
// R3 - an eight-bit feedback ratio is held, valid from 14 to 255, reset to zero.
// R4 - filter bits 7:6 pick the second pole resistor and the filter register resets to 0x7F.
// R5 - filter bits 5:3 pick the zero resistor, reset code 111.
// R6 - filter bits 2:0 pick the first pole capacitor, reset code 111.
// R7 - while post-divider control bit 1 is set the post-divider is held in reset.
// R8 - post-divider control bit 0 bypasses the internal zero resistor.
// R9 - software reruns calibration or pulses the post-divider reset after changing its ratio.
// R10 - reads return the last value written to defined bits; reserved bits read zero.
`timescale 1ns/1ns
module olz_config_regs (
    input wire logic i_clk,
    input wire logic i_reset_n,
    input wire logic [17:0] i_avs_address,
    input wire logic i_avs_read,
    input wire logic i_avs_write,
    input wire logic [31:0] i_avs_writedata,
    input wire logic [3:0] i_avs_byteenable,
    output logic [31:0] o_avs_readdata,
    output logic o_avs_waitrequest,
    output logic [1:0] o_avs_response,
    output logic [6:0] o_pump_current_code,
    output logic [7:0] o_loop_feedback_ratio,
    output logic o_ratio_valid,
    output logic [1:0] o_second_pole_resistor_sel,
    output logic [2:0] o_zero_resistor_sel,
    output logic [2:0] o_first_pole_capacitor_sel,
    output logic [10:0] o_zero_resistor_ohm,
    output logic [8:0] o_second_pole_resistor_ohm,
    output logic [7:0] o_first_pole_capacitor_pf,
    output logic o_zero_resistor_bypass,
    output logic o_output_post_divider_hold
);
    // ==========================================================
    // bus handshake state
    typedef enum logic [2:0] {
        OLZ_IDLE = 3'b001,
        OLZ_ACK = 3'b010,
        OLZ_DONE = 3'b100
    } olz_state_e;

    localparam logic [1:0] RESP_OK = 2'h0;
    localparam logic [1:0] RESP_DECERR = 2'h3;

    olz_state_e state_reg, state_next;
    logic [6:0] pump_reg, pump_next;
    logic [7:0] ratio_reg, ratio_next;
    logic [7:0] filter_reg, filter_next;
    logic hold_reg, hold_next;
    logic bypass_reg, bypass_next;
    logic [31:0] rdata_reg, rdata_next;
    logic [1:0] resp_reg, resp_next;
    logic wait_reg, wait_next;
    logic [1:0] rp2_reg, rp2_next;
    logic [2:0] rz_reg, rz_next;
    logic [2:0] cp1_reg, cp1_next;
    logic [10:0] rzo_reg, rzo_next;
    logic [8:0] rp2o_reg, rp2o_next;
    logic [7:0] cp1p_reg, cp1p_next;
    logic rv_reg, rv_next;

    logic [15:0] idx;
    logic hit_pump, hit_ratio, hit_filter, hit_post, hit_any;
    logic [7:0] wbyte;
    logic wr_ok;
    logic take_req, commit_wr;

    olz_cfg_if cfg ();

    // ==========================================================
    // decoder of component values
    assign cfg.pump_code = pump_reg;
    assign cfg.ratio = ratio_reg;
    assign cfg.filter = filter_reg;
    assign cfg.bypass = bypass_reg;

    olz_filter_decode u_decode (
        .cfg(cfg)
    );

    // ==========================================================
    // address decode: word address index, low two bits must be zero
    always_comb begin
        idx = i_avs_address[17:2];
        hit_pump = 1'b0;
        hit_ratio = 1'b0;
        hit_filter = 1'b0;
        hit_post = 1'b0;
        if (i_avs_address[1:0] != 2'h0) begin
            hit_pump = 1'b0;
        end else if (idx == olz_pkg::IDX_PUMP) begin
            hit_pump = 1'b1;
        end else if (idx == olz_pkg::IDX_RATIO) begin
            hit_ratio = 1'b1;
        end else if (idx == olz_pkg::IDX_FILTER) begin
            hit_filter = 1'b1;
        end else if (idx == olz_pkg::IDX_POSTDIV) begin
            hit_post = 1'b1;
        end
        hit_any = hit_pump | hit_ratio | hit_filter | hit_post;
        wbyte = i_avs_writedata[7:0];
        // only byte lane 0 carries register data; other lanes are ignored
        wr_ok = i_avs_write && hit_any && i_avs_byteenable[0];
    end

    // ==========================================================
    // request qualification
    always_comb begin
        take_req = (state_reg == OLZ_IDLE) && (i_avs_read || i_avs_write);
        commit_wr = (state_reg == OLZ_ACK) && wr_ok;
    end

    // ==========================================================
    // handshake: one wait cycle, then waitrequest drops for one edge
    // c0: request taken in idle, reply data captured at the closing edge
    // c1: waitrequest low, a write lands at the closing edge
    // c2: gap, waitrequest high again, further requests are not taken
    always_comb begin
        state_next = state_reg;
        wait_next = 1'b1;
        case (state_reg)
            OLZ_IDLE: begin
                if (i_avs_read || i_avs_write) begin
                    state_next = OLZ_ACK;
                    wait_next = 1'b0;
                end
            end
            OLZ_ACK: begin
                state_next = OLZ_DONE;
            end
            OLZ_DONE: begin
                // gap cycle lets the master drop its request before a new one
                state_next = OLZ_IDLE;
            end
            default: begin
                state_next = OLZ_IDLE;
            end
        endcase
    end

    // ==========================================================
    // read reply: data and response are captured when the request is taken
    always_comb begin
        rdata_next = rdata_reg;
        resp_next = resp_reg;
        if (take_req) begin
            resp_next = hit_any ? RESP_OK : RESP_DECERR;
            rdata_next = 32'h0000_0000;
            if (i_avs_read) begin
                // reserved and unused bits return zero
                if (hit_pump) begin
                    rdata_next = {25'h0, pump_reg}; // R10
                end else if (hit_ratio) begin
                    rdata_next = {24'h0, ratio_reg}; // R10
                end else if (hit_filter) begin
                    rdata_next = {24'h0, filter_reg}; // R10
                end else if (hit_post) begin
                    rdata_next = {30'h0, hold_reg, bypass_reg}; // R10
                end
            end
        end
    end

    // ==========================================================
    // configuration registers
    always_comb begin
        pump_next = pump_reg;
        ratio_next = ratio_reg;
        filter_next = filter_reg;
        hold_next = hold_reg;
        bypass_next = bypass_reg;
        // a write lands only on the edge at which the master sees waitrequest low
        if (commit_wr) begin
            if (hit_pump) begin
                pump_next = wbyte[olz_pkg::PUMP_MSB:0]; // R1
            end else if (hit_ratio) begin
                // stored even below the minimum ratio; the valid flag reports it
                ratio_next = wbyte; // R3
            end else if (hit_filter) begin
                filter_next = wbyte; // R4 R5 R6
            end else if (hit_post) begin
                hold_next = wbyte[olz_pkg::HOLD_BIT]; // R7
                bypass_next = wbyte[olz_pkg::BYPASS_BIT]; // R8
            end
        end
    end

    // ==========================================================
    // registered copies of decoded values so every output is a flop
    // they trail the filter, bypass and ratio registers by one clock
    always_comb begin
        rp2_next = cfg.rp2_sel;
        rz_next = cfg.rz_sel;
        cp1_next = cfg.cp1_sel;
        rzo_next = cfg.rz_ohm;
        rp2o_next = cfg.rp2_ohm;
        cp1p_next = cfg.cp1_pf;
        rv_next = cfg.ratio_valid;
    end

    // ==========================================================
    // handshake registers
    always_ff @(posedge i_clk) begin
        if (!i_reset_n) begin
            state_reg <= OLZ_IDLE;
            wait_reg <= 1'b1;
        end else begin
            state_reg <= state_next;
            wait_reg <= wait_next;
        end
    end

    // ==========================================================
    // reply registers
    always_ff @(posedge i_clk) begin
        if (!i_reset_n) begin
            rdata_reg <= 32'h0000_0000;
            resp_reg <= RESP_OK;
        end else begin
            rdata_reg <= rdata_next;
            resp_reg <= resp_next;
        end
    end

    // ==========================================================
    // configuration register flops
    always_ff @(posedge i_clk) begin
        if (!i_reset_n) begin
            pump_reg <= olz_pkg::PUMP_RST; // R2
            ratio_reg <= olz_pkg::RATIO_RST; // R3
            filter_reg <= olz_pkg::FILTER_RST; // R4 R5 R6
            hold_reg <= olz_pkg::POSTDIV_RST[olz_pkg::HOLD_BIT]; // R7
            bypass_reg <= olz_pkg::POSTDIV_RST[olz_pkg::BYPASS_BIT]; // R8
        end else begin
            pump_reg <= pump_next;
            ratio_reg <= ratio_next;
            filter_reg <= filter_next;
            hold_reg <= hold_next;
            bypass_reg <= bypass_next;
        end
    end

    // ==========================================================
    // decoded copies; out of reset they match the decode of the filter reset value
    always_ff @(posedge i_clk) begin
        if (!i_reset_n) begin
            rp2_reg <= olz_pkg::FILTER_RST[olz_pkg::RP2_MSB:olz_pkg::RP2_LSB];
            rz_reg <= olz_pkg::FILTER_RST[olz_pkg::RZ_MSB:olz_pkg::RZ_LSB];
            cp1_reg <= olz_pkg::FILTER_RST[olz_pkg::CP1_MSB:olz_pkg::CP1_LSB];
            rzo_reg <= 11'd680;
            rp2o_reg <= 9'd333;
            cp1p_reg <= 8'd150;
            rv_reg <= 1'b0;
        end else begin
            rp2_reg <= rp2_next;
            rz_reg <= rz_next;
            cp1_reg <= cp1_next;
            rzo_reg <= rzo_next;
            rp2o_reg <= rp2o_next;
            cp1p_reg <= cp1p_next;
            rv_reg <= rv_next;
        end
    end

    // ==========================================================
    // outputs
    assign o_avs_readdata = rdata_reg;
    assign o_avs_waitrequest = wait_reg;
    assign o_avs_response = resp_reg;

    // configuration fields
    assign o_pump_current_code = pump_reg; // R1
    assign o_loop_feedback_ratio = ratio_reg; // R3

    // decoded status
    assign o_ratio_valid = rv_reg;
    assign o_second_pole_resistor_sel = rp2_reg;
    assign o_zero_resistor_sel = rz_reg;
    assign o_first_pole_capacitor_sel = cp1_reg;
    assign o_zero_resistor_ohm = rzo_reg;
    assign o_second_pole_resistor_ohm = rp2o_reg;
    assign o_first_pole_capacitor_pf = cp1p_reg;
    assign o_zero_resistor_bypass = bypass_reg; // R8
    // the divider stays held as long as software leaves the bit set
    assign o_output_post_divider_hold = hold_reg; // R7
endmodule // olz_config_regs

/* include/olz_pkg.sv */
// package: register map, field layout and reset values of the output loop zero config bank
package olz_pkg;
    // register indices; the byte address on the bus is four times the index
    localparam logic [15:0] IDX_PUMP = 16'h0430;
    localparam logic [15:0] IDX_RATIO = 16'h0431;
    localparam logic [15:0] IDX_FILTER = 16'h0432;
    localparam logic [15:0] IDX_POSTDIV = 16'h0433;
    localparam int ADDR_W = 16;
    // field positions
    localparam int PUMP_MSB = 6;
    localparam int RP2_MSB = 7;
    localparam int RP2_LSB = 6;
    localparam int RZ_MSB = 5;
    localparam int RZ_LSB = 3;
    localparam int CP1_MSB = 2;
    localparam int CP1_LSB = 0;
    localparam int HOLD_BIT = 1;
    localparam int BYPASS_BIT = 0;
    // reset values
    localparam logic [6:0] PUMP_RST = 7'h2E;
    localparam logic [7:0] RATIO_RST = 8'h00;
    localparam logic [7:0] FILTER_RST = 8'h7F;
    localparam logic [1:0] POSTDIV_RST = 2'h0;
    // feedback ratio limits
    localparam logic [7:0] RATIO_MIN = 8'h0E;
    localparam logic [7:0] RATIO_MAX = 8'hFF;
    // pump step in nA
    localparam int PUMP_STEP_NA = 3500;
endpackage

/* include/olz_cfg_if.sv */
// interface: loop configuration passed from the register bank to the decoder, decoded values passed back
`timescale 1ns/1ns
interface olz_cfg_if;
    logic [6:0] pump_code;
    logic [7:0] ratio;
    logic [7:0] filter;
    logic bypass;
    logic [1:0] rp2_sel;
    logic [2:0] rz_sel;
    logic [2:0] cp1_sel;
    logic [10:0] rz_ohm;
    logic [8:0] rp2_ohm;
    logic [7:0] cp1_pf;
    logic ratio_valid;
    modport bank (output pump_code, ratio, filter, bypass,
        input rp2_sel, rz_sel, cp1_sel, rz_ohm, rp2_ohm, cp1_pf, ratio_valid);
    modport dec (input pump_code, ratio, filter, bypass,
        output rp2_sel, rz_sel, cp1_sel, rz_ohm, rp2_ohm, cp1_pf, ratio_valid);
endinterface

/* verilog/olz_filter_decode.sv */
// module: decodes loop filter codes into component values and checks the feedback ratio
`timescale 1ns/1ns
module olz_filter_decode (
    olz_cfg_if.dec cfg
);
    always_comb begin
        cfg.rp2_sel = cfg.filter[olz_pkg::RP2_MSB:olz_pkg::RP2_LSB]; // R4
        cfg.rz_sel = cfg.filter[olz_pkg::RZ_MSB:olz_pkg::RZ_LSB]; // R5
        cfg.cp1_sel = cfg.filter[olz_pkg::CP1_MSB:olz_pkg::CP1_LSB]; // R6
        case (cfg.rp2_sel) // R4
            2'h0: cfg.rp2_ohm = 9'd500;
            2'h1: cfg.rp2_ohm = 9'd333;
            2'h2: cfg.rp2_ohm = 9'd250;
            default: cfg.rp2_ohm = 9'd200;
        endcase
        // bypass forces zero ohms regardless of the selected code
        if (cfg.bypass) begin // R8
            cfg.rz_ohm = 11'd0;
        end else begin
            case (cfg.rz_sel) // R5
                3'h0: cfg.rz_ohm = 11'd1500;
                3'h1: cfg.rz_ohm = 11'd1250;
                3'h2: cfg.rz_ohm = 11'd1000;
                3'h3: cfg.rz_ohm = 11'd930;
                3'h4: cfg.rz_ohm = 11'd1250;
                3'h5: cfg.rz_ohm = 11'd1000;
                3'h6: cfg.rz_ohm = 11'd750;
                default: cfg.rz_ohm = 11'd680;
            endcase
        end
        case (cfg.cp1_sel) // R6
            3'h0: cfg.cp1_pf = 8'd10;
            3'h1: cfg.cp1_pf = 8'd30;
            3'h2: cfg.cp1_pf = 8'd40;
            3'h3: cfg.cp1_pf = 8'd70;
            3'h4: cfg.cp1_pf = 8'd90;
            3'h5: cfg.cp1_pf = 8'd110;
            3'h6: cfg.cp1_pf = 8'd130;
            default: cfg.cp1_pf = 8'd150;
        endcase
        cfg.ratio_valid = (cfg.ratio >= olz_pkg::RATIO_MIN)
            && (cfg.ratio <= olz_pkg::RATIO_MAX); // R3
    end
endmodule // olz_filter_decode

/* testbench/olz_config_regs_properties.sv */
// checker: concurrent properties of the output loop zero config bank
`timescale 1ns/1ns
module olz_config_regs_properties (
    input wire logic i_clk,
    input wire logic i_reset_n,
    input wire logic [17:0] i_avs_address,
    input wire logic i_avs_read,
    input wire logic i_avs_write,
    input wire logic [31:0] i_avs_writedata,
    input wire logic [3:0] i_avs_byteenable,
    input wire logic [31:0] o_avs_readdata,
    input wire logic o_avs_waitrequest,
    input wire logic [1:0] o_avs_response,
    input wire logic [6:0] o_pump_current_code,
    input wire logic [7:0] o_loop_feedback_ratio,
    input wire logic o_ratio_valid,
    input wire logic [1:0] o_second_pole_resistor_sel,
    input wire logic [2:0] o_zero_resistor_sel,
    input wire logic [2:0] o_first_pole_capacitor_sel,
    input wire logic [10:0] o_zero_resistor_ohm,
    input wire logic [8:0] o_second_pole_resistor_ohm,
    input wire logic [7:0] o_first_pole_capacitor_pf,
    input wire logic o_zero_resistor_bypass,
    input wire logic o_output_post_divider_hold
);
    localparam logic [8:0] RP2_T [4] = '{9'h1F4, 9'h14D, 9'h0FA, 9'h0C8};
    localparam logic [10:0] RZ_T [8] = '{11'h5DC, 11'h4E2, 11'h3E8, 11'h3A2,
        11'h4E2, 11'h3E8, 11'h2EE, 11'h2A8};
    localparam logic [7:0] CP_T [8] = '{8'h0A, 8'h1E, 8'h28, 8'h46, 8'h5A, 8'h6E, 8'h82, 8'h96};
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_reset_n);
    // ==========================================
    // completed bus cycles
    sequence s_wr_done(logic [17:0] a);
        i_avs_write && !o_avs_waitrequest && i_avs_byteenable[0] && i_avs_address == a;
    endsequence
    sequence s_rd_done(logic [17:0] a);
        i_avs_read && !o_avs_waitrequest && i_avs_address == a;
    endsequence
    // ==========================================
    // properties
    property p_reset_vals;
        $rose(i_reset_n) |-> o_pump_current_code == 7'h2E && o_loop_feedback_ratio == 8'h00
            && o_second_pole_resistor_sel == 2'h1 && o_zero_resistor_sel == 3'h7
            && o_first_pole_capacitor_sel == 3'h7 && !o_output_post_divider_hold
            && !o_zero_resistor_bypass;
    endproperty
    property p_ratio_valid;
        o_ratio_valid == ($past(o_loop_feedback_ratio) >= 8'h0E);
    endproperty
    // decoded values change with their select, but the zero resistor value lags the bypass bit by one cycle, so judge only settled inputs
    property p_rp2;
        $stable(o_second_pole_resistor_sel)
            |-> o_second_pole_resistor_ohm == RP2_T[o_second_pole_resistor_sel];
    endproperty
    property p_rz;
        $stable(o_zero_resistor_sel) && $stable(o_zero_resistor_bypass) |-> o_zero_resistor_ohm
            == (o_zero_resistor_bypass ? 11'h000 : RZ_T[o_zero_resistor_sel]);
    endproperty
    property p_cp1;
        $stable(o_first_pole_capacitor_sel)
            |-> o_first_pole_capacitor_pf == CP_T[o_first_pole_capacitor_sel];
    endproperty
    property p_pump_wr;
        s_wr_done(18'h010C0) |=> o_pump_current_code == $past(i_avs_writedata[6:0]);
    endproperty
    property p_postdiv_wr;
        s_wr_done(18'h010CC) |=> o_output_post_divider_hold == $past(i_avs_writedata[1])
            && o_zero_resistor_bypass == $past(i_avs_writedata[0]);
    endproperty
    property p_rd_pump;
        s_rd_done(18'h010C0) |-> o_avs_readdata == {25'h0, o_pump_current_code}
            && o_avs_response == 2'h0;
    endproperty
    property p_unmapped;
        s_rd_done(18'h00000) |-> o_avs_response == 2'h3 && o_avs_readdata == 32'h0;
    endproperty
    a_reset_vals: assert property (p_reset_vals)
        else $error("reset values wrong");
    a_ratio_valid: assert property (p_ratio_valid)
        else $error("ratio valid flag wrong");
    a_rp2: assert property (p_rp2)
        else $error("second pole resistor value wrong");
    a_rz: assert property (p_rz)
        else $error("zero resistor value wrong");
    a_cp1: assert property (p_cp1)
        else $error("first pole capacitor value wrong");
    a_pump_wr: assert property (p_pump_wr)
        else $error("pump code not written");
    a_postdiv_wr: assert property (p_postdiv_wr)
        else $error("post divider control not written");
    a_rd_pump: assert property (p_rd_pump)
        else $error("pump readback wrong");
    a_unmapped: assert property (p_unmapped)
        else $error("unmapped read not refused");
endmodule // olz_config_regs_properties

bind olz_config_regs olz_config_regs_properties chk_u (.i_clk(i_clk), .i_reset_n(i_reset_n),
    .i_avs_address(i_avs_address), .i_avs_read(i_avs_read), .i_avs_write(i_avs_write),
    .i_avs_writedata(i_avs_writedata), .i_avs_byteenable(i_avs_byteenable),
    .o_avs_readdata(o_avs_readdata), .o_avs_waitrequest(o_avs_waitrequest),
    .o_avs_response(o_avs_response), .o_pump_current_code(o_pump_current_code),
    .o_loop_feedback_ratio(o_loop_feedback_ratio), .o_ratio_valid(o_ratio_valid),
    .o_second_pole_resistor_sel(o_second_pole_resistor_sel),
    .o_zero_resistor_sel(o_zero_resistor_sel),
    .o_first_pole_capacitor_sel(o_first_pole_capacitor_sel),
    .o_zero_resistor_ohm(o_zero_resistor_ohm),
    .o_second_pole_resistor_ohm(o_second_pole_resistor_ohm),
    .o_first_pole_capacitor_pf(o_first_pole_capacitor_pf),
    .o_zero_resistor_bypass(o_zero_resistor_bypass),
    .o_output_post_divider_hold(o_output_post_divider_hold));

/* testbench/testbench.sv */
// testbench: register bank checks over the Avalon-MM slave port
`timescale 1ns/1ns
`define CHK(nm, e, s) begin samples_checked++; if ((s) !== (e)) begin n_errors++; $display("MISMATCH %s exp %0h got %0h", nm, e, s); end end
module testbench;
    logic i_clk = 1'b0;
    logic i_reset_n = 1'b0;
    logic [17:0] i_avs_address = 18'h0;
    logic i_avs_read = 1'b0;
    logic i_avs_write = 1'b0;
    logic [31:0] i_avs_writedata = 32'h0;
    logic [3:0] i_avs_byteenable = 4'hF;
    logic [31:0] o_avs_readdata;
    logic o_avs_waitrequest;
    logic [1:0] o_avs_response;
    logic o_ratio_valid;
    logic [6:0] o_pump_current_code;
    logic [7:0] o_loop_feedback_ratio;
    logic [1:0] o_second_pole_resistor_sel;
    logic [2:0] o_zero_resistor_sel;
    logic [2:0] o_first_pole_capacitor_sel;
    logic [10:0] o_zero_resistor_ohm;
    logic [8:0] o_second_pole_resistor_ohm;
    logic [7:0] o_first_pole_capacitor_pf;
    logic o_zero_resistor_bypass;
    logic o_output_post_divider_hold;
    logic [31:0] rd;
    logic [1:0] rsp;
    int n_errors = 0;
    int samples_checked = 0;
    // rows: address, write data, expected readback
    logic [33:0] rows [14] = '{{18'h010C0, 8'hFF, 8'h7F}, {18'h010C0, 8'h01, 8'h01},
        {18'h010C4, 8'h0D, 8'h0D}, {18'h010C4, 8'hFF, 8'hFF}, {18'h010C8, 8'h00, 8'h00},
        {18'h010C8, 8'h49, 8'h49}, {18'h010C8, 8'h92, 8'h92}, {18'h010C8, 8'hDB, 8'hDB},
        {18'h010C8, 8'h24, 8'h24}, {18'h010C8, 8'h6D, 8'h6D}, {18'h010C8, 8'hB6, 8'hB6},
        {18'h010CC, 8'hFF, 8'h03}, {18'h010CC, 8'h02, 8'h02}, {18'h010CC, 8'h01, 8'h01}};
    always #10 i_clk = ~i_clk;
    olz_config_regs dut_u (.i_clk(i_clk), .i_reset_n(i_reset_n), .i_avs_address(i_avs_address),
        .i_avs_read(i_avs_read), .i_avs_write(i_avs_write), .i_avs_writedata(i_avs_writedata),
        .i_avs_byteenable(i_avs_byteenable), .o_avs_readdata(o_avs_readdata),
        .o_avs_waitrequest(o_avs_waitrequest), .o_avs_response(o_avs_response),
        .o_pump_current_code(o_pump_current_code),
        .o_loop_feedback_ratio(o_loop_feedback_ratio), .o_ratio_valid(o_ratio_valid),
        .o_second_pole_resistor_sel(o_second_pole_resistor_sel),
        .o_zero_resistor_sel(o_zero_resistor_sel),
        .o_first_pole_capacitor_sel(o_first_pole_capacitor_sel),
        .o_zero_resistor_ohm(o_zero_resistor_ohm),
        .o_second_pole_resistor_ohm(o_second_pole_resistor_ohm),
        .o_first_pole_capacitor_pf(o_first_pole_capacitor_pf),
        .o_zero_resistor_bypass(o_zero_resistor_bypass),
        .o_output_post_divider_hold(o_output_post_divider_hold));
    // ==========================================
    // bus master: hold the request until waitrequest is sampled low
    task automatic xfer(input logic w, input logic [17:0] a, input logic [7:0] d,
        input logic [3:0] be);
        i_avs_address <= a;
        i_avs_writedata <= {24'h0, d};
        i_avs_byteenable <= be;
        i_avs_write <= w;
        i_avs_read <= !w;
        // no cycle count is assumed; a hang is ended by the watchdog
        do begin
            @(posedge i_clk);
        end while (o_avs_waitrequest !== 1'b0);
        rd = o_avs_readdata;
        rsp = o_avs_response;
        i_avs_write <= 1'b0;
        i_avs_read <= 1'b0;
        @(posedge i_clk);
    endtask
    task automatic close_out();
        $display("checks %0d errors %0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    initial begin
        repeat (5000) @(posedge i_clk);
        n_errors++;
        close_out();
    end
    // ==========================================
    // sequence
    initial begin
        repeat (10) @(posedge i_clk);
        i_reset_n <= 1'b1;
        @(posedge i_clk);
        xfer(1'b0, 18'h010C0, 8'h00, 4'hF); `CHK("pump rst", 32'h2E, rd)
        xfer(1'b0, 18'h010C4, 8'h00, 4'hF); `CHK("ratio rst", 32'h00, rd)
        xfer(1'b0, 18'h010C8, 8'h00, 4'hF); `CHK("filter rst", 32'h7F, rd)
        xfer(1'b0, 18'h010CC, 8'h00, 4'hF); `CHK("postdiv rst", 32'h00, rd)
        `CHK("rsp ok", 2'h0, rsp)
        `CHK("pump out rst", 7'h2E, o_pump_current_code)
        `CHK("rp2 ohm rst", 9'h14D, o_second_pole_resistor_ohm)
        `CHK("rz ohm rst", 11'h2A8, o_zero_resistor_ohm)
        `CHK("cp1 pf rst", 8'h96, o_first_pole_capacitor_pf)
        foreach (rows[i]) begin
            xfer(1'b1, rows[i][33:16], rows[i][15:8], 4'hF);
            xfer(1'b0, rows[i][33:16], 8'h00, 4'hF);
            `CHK("readback", {24'h0, rows[i][7:0]}, rd)
        end
        // last filter row 0xB6 and last control row 0x01 are in force
        `CHK("rp2 sel", 2'h2, o_second_pole_resistor_sel)
        `CHK("rz sel", 3'h6, o_zero_resistor_sel)
        `CHK("cp1 sel", 3'h6, o_first_pole_capacitor_sel)
        `CHK("rp2 ohm", 9'h0FA, o_second_pole_resistor_ohm)
        `CHK("rz bypassed", 11'h000, o_zero_resistor_ohm)
        `CHK("cp1 pf", 8'h82, o_first_pole_capacitor_pf)
        `CHK("bypass on", 1'b1, o_zero_resistor_bypass)
        `CHK("hold off", 1'b0, o_output_post_divider_hold)
        // software pulses the post-divider reset after a ratio change
        xfer(1'b1, 18'h010CC, 8'h02, 4'hF); `CHK("hold on", 1'b1, o_output_post_divider_hold)
        xfer(1'b1, 18'h010CC, 8'h00, 4'hF); `CHK("hold rel", 1'b0, o_output_post_divider_hold)
        @(posedge i_clk); `CHK("rz ohm", 11'h2EE, o_zero_resistor_ohm)
        `CHK("bypass off", 1'b0, o_zero_resistor_bypass)
        // awkward cases: lower ratio bound, dead byte lane, unmapped, mid-run reset
        xfer(1'b1, 18'h010C4, 8'h0D, 4'hF);
        repeat (2) @(posedge i_clk); `CHK("valid 13", 1'b0, o_ratio_valid)
        xfer(1'b1, 18'h010C4, 8'h0E, 4'hF);
        repeat (2) @(posedge i_clk); `CHK("valid 14", 1'b1, o_ratio_valid)
        `CHK("ratio out", 8'h0E, o_loop_feedback_ratio)
        xfer(1'b1, 18'h010C4, 8'h55, 4'h0);
        xfer(1'b0, 18'h010C4, 8'h00, 4'hF); `CHK("no lane", 32'h0E, rd)
        xfer(1'b1, 18'h00000, 8'h55, 4'hF); `CHK("unm wr rsp", 2'h3, rsp)
        xfer(1'b0, 18'h00000, 8'h00, 4'hF); `CHK("unm rsp", 2'h3, rsp)
        xfer(1'b0, 18'h010C1, 8'h00, 4'hF); `CHK("misalign rsp", 2'h3, rsp)
        `CHK("misalign rd", 32'h0, rd)
        xfer(1'b1, 18'h010C0, 8'h13, 4'hF);
        i_reset_n <= 1'b0;
        repeat (2) @(posedge i_clk);
        i_reset_n <= 1'b1;
        @(posedge i_clk);
        xfer(1'b0, 18'h010C0, 8'h00, 4'hF); `CHK("pump rst2", 32'h2E, rd)
        `CHK("ratio rst2", 8'h00, o_loop_feedback_ratio)
        close_out();
    end
endmodule // testbench
